// *** rtl/dram_pd_timing_regs.svh ***
`ifndef DRAM_PD_TIMING_REGS_SVH
`define DRAM_PD_TIMING_REGS_SVH

// Fabric clock period and divider that makes the memory clock
`define CLK_PERIOD_PS 4000
`define CK_DIV 2

// Power-down exit to command
`define XP_NCK 3
`define XP_PS 6000
`define XPDLL_NCK 10
`define XPDLL_PS 24000

// Clock-enable pulse width, slower grade figure
`define CKE_NCK 3
`define CKE_PS 5625

// Command to power-down entry, plus mode-register set spacing
`define CPDED_NCK 1
`define ACTPDEN_NCK 1
`define PRPDEN_NCK 1
`define REFPDEN_NCK 1
`define RDPDEN_EXTRA 5
`define WRPDEN_BL8_EXTRA 4
`define WRPDEN_BC4_EXTRA 2
`define WR_PS 15000
`define MOD_NCK 12
`define MOD_PS 15000
`define MRD_NCK 4

// Termination high times
`define TERM_HIGH_TIME_SHORT_NCK 4
`define TERM_HIGH_TIME_LONG_NCK 6

// Write leveling
`define WLMRD_NCK 40
`define WLDQSEN_NCK 25
`define WLO_PS 9000

// Longest power-down
`define REFI_PS 7800000
`define PD_MAX_REFI 9

// Row, column and write-enable strobe codes (active low)
`define PIN_ACT 3'h3
`define PIN_PRE 3'h2
`define PIN_RD 3'h5
`define PIN_WR 3'h4
`define PIN_REF 3'h1
`define PIN_MRS 3'h0
`define PIN_NOP 3'h7
`define AP_BIT 10

`endif

// *** rtl/dram_pd_timing_pkg.sv ***
`include "dram_pd_timing_regs.svh"

package dram_pd_timing_pkg;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_PRE = 4'h2,
    CMD_PREA = 4'h3,
    CMD_RD = 4'h4,
    CMD_RDA = 4'h5,
    CMD_WR = 4'h6,
    CMD_WRA = 4'h7,
    CMD_REF = 4'h8,
    CMD_MRS = 4'h9,
    CMD_PDE = 4'hA,
    CMD_PDX = 4'hB,
    CMD_WLPULSE = 4'hC
  } cmd_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_PD = 3'h2,
    ST_HALT = 3'h4
  } state_t;

  // User request, held stable until acknowledged
  typedef struct packed {
    cmd_t cmd;
    logic bl8;
    logic odt;
    logic wlMode;
    logic [2:0] bank;
    logic [13:0] addr;
  } req_t;

  // Command pins towards the memory
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [2:0] ba;
    logic [13:0] addr;
  } pins_t;

  function automatic int ceilDiv(input int num, input int den);
    return (num + den - 1) / den;
  endfunction : ceilDiv

  // Larger of a cycle count and a time rounded up to memory cycles
  function automatic int cycles(input int nck, input int ps);
    int t;
    t = ceilDiv(ps, `CLK_PERIOD_PS * `CK_DIV);
    return (t > nck) ? t : nck;
  endfunction : cycles

endpackage : dram_pd_timing_pkg

// *** rtl/sync_2ff.sv ***
`timescale 1ns/1ps

module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced_q
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad
    $error("sync_2ff width must be positive");
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      synced_q <= '0;
    end else if (ce) begin
      meta_q <= async;
      synced_q <= meta_q;
    end
  end

endmodule : sync_2ff

// *** rtl/nck_timer.sv ***
`timescale 1ns/1ps

module nck_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic step,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic idle
);

  logic [W-1:0] count_q;

  if (W < 2) begin : g_bad
    $error("nck_timer width must be at least 2");
  end

  // Load keeps the longer of pending and new wait; step is one memory clock edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (load && (value > count_q)) begin
      count_q <= value;
    end else if (step && (count_q != '0)) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign idle = (count_q == '0);

endmodule : nck_timer

// *** rtl/dram_pd_timing_host.sv ***
`timescale 1ns/1ps
`include "dram_pd_timing_regs.svh"

// Function
// - After power-down exit wait max(3 cycles, 6 ns) before commands.
// - After DLL-frozen exit wait max(10 cycles, 24 ns) before DLL commands.
// - Hold clock enable at each level max(3 cycles, 5.625 ns).
// - Power-down lasts at least the pulse minimum, at most nine refresh intervals.
// - One cycle from activate to power-down entry.
// - One cycle from precharge or precharge-all to power-down entry.
// - Read to power-down entry waits read latency plus five.
// - Write to power-down waits write latency plus 4 plus rounded recovery.
// - Auto-precharge write waits write latency plus 4 plus programmed recovery plus one.
// - Fixed burst chop 4 uses write latency plus 2 instead.
// - One cycle from refresh to power-down entry.
// - Mode-register set to power-down waits the update delay.
// - Termination high at least 4 cycles without burst-8 write.
// - Termination high at least 6 cycles with accompanying burst-8 write.
// - Write leveling waits 40 cycles before first rising strobe edge.
// - Write leveling waits 25 cycles before driving the strobe pair.
// - Cycle minima count real memory clock edges, not elapsed time.
// - Illegal timing demands memory reset and full reinitialisation.
// - Mode-register set commands spaced at least 4 cycles.
// - Read, read auto-precharge and termination change need a locked DLL.
// - Recovery time converts to cycles by rounding up.
module dram_pd_timing_host
  import dram_pd_timing_pkg::*;
#(
  parameter int PDW = 14,
  parameter int PD_MAX_NCK = `PD_MAX_REFI * (`REFI_PS / (`CLK_PERIOD_PS * `CK_DIV))
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic reqValid,
  input wire req_t req,
  output logic reqAck_q,
  input wire logic [4:0] readLatency,
  input wire logic [4:0] writeLatency,
  input wire logic [4:0] wrCycles,
  input wire logic fixedBurstChopMode,
  input wire logic dllFrozenPd,
  output logic ddrCk_q,
  output logic ddrCkN_q,
  output logic cke_q,
  output pins_t cmdPins_q,
  output logic odt_q,
  output logic dqs_q,
  output logic dqsN_q,
  output logic dqsOe_q,
  input wire logic wlDq,
  output logic wlResult_q,
  output logic wlResultValid_q,
  output logic inPowerDown_q,
  output logic reinitNeeded_q
);

  if ((PDW < 4) || (PDW > 30) || (PD_MAX_NCK < 4) || (PD_MAX_NCK >= (2 ** PDW))) begin : g_bad
    $error("power-down limit does not fit its counter");
  end

  // Waits in memory clock cycles, max of count and rounded-up time
  localparam logic [3:0] XP_C = 4'(cycles(`XP_NCK, `XP_PS));
  localparam logic [3:0] XPDLL_C = 4'(cycles(`XPDLL_NCK, `XPDLL_PS));
  localparam logic [3:0] CKE_C = 4'(cycles(`CKE_NCK, `CKE_PS));
  localparam logic [7:0] MOD_C = 8'(cycles(`MOD_NCK, `MOD_PS));
  localparam logic [7:0] WR_C = 8'(cycles(1, `WR_PS));
  localparam logic [3:0] MRD_C = 4'(`MRD_NCK);
  localparam logic [3:0] TERM_HIGH_TIME_SHORT_C = 4'(`TERM_HIGH_TIME_SHORT_NCK);
  localparam logic [3:0] TERM_HIGH_TIME_LONG_C = 4'(`TERM_HIGH_TIME_LONG_NCK);
  localparam logic [5:0] WLMRD_C = 6'(`WLMRD_NCK);
  localparam logic [5:0] WLDQSEN_C = 6'(`WLDQSEN_NCK);
  // Fabric cycles from strobe edge to a settled, synchronised level
  localparam logic [2:0] WLO_C = 3'(ceilDiv(`WLO_PS, `CLK_PERIOD_PS) + 2);
  localparam logic [PDW-1:0] PD_LAST = PDW'(PD_MAX_NCK - 1);

  state_t state_q;
  logic tick;
  logic legal;
  logic cmdOk;
  logic odtOk;
  logic take;
  logic pdExitNow;
  logic isWrite;
  logic isRead;
  logic [7:0] pdEnVal;
  logic [7:0] wrBase;
  logic pdEnIdle;
  logic exitIdle;
  logic dllIdle;
  logic ckeIdle;
  logic mrdIdle;
  logic termIdle;
  logic wlDrvIdle;
  logic wlEdgIdle;
  logic [PDW-1:0] pdCount_q;
  logic wlMode_q;
  logic wlSync;
  logic [2:0] wlWait_q;

  // One slot per memory clock: pins change as the clock falls, stable at the rise
  assign tick = ce & ddrCk_q;

  // Memory clock made by dividing the fabric clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ddrCk_q <= 1'b0;
      ddrCkN_q <= 1'b1;
    end else if (ce) begin
      ddrCk_q <= ~ddrCk_q;
      ddrCkN_q <= ddrCk_q;
    end
  end

  // Decode the pending request
  always_comb begin
    isRead = (req.cmd == CMD_RD) || (req.cmd == CMD_RDA);
    isWrite = (req.cmd == CMD_WR) || (req.cmd == CMD_WRA);
    wrBase = 8'({3'h0, writeLatency}) + (fixedBurstChopMode ? 8'(`WRPDEN_BC4_EXTRA) : 8'(`WRPDEN_BL8_EXTRA));
    legal = 1'b1;
    cmdOk = 1'b0;
    pdEnVal = 8'h00;
    unique case (req.cmd)
      CMD_NOP, CMD_PDX: begin
        cmdOk = 1'b1;
      end
      CMD_ACT: begin
        cmdOk = exitIdle;
        pdEnVal = 8'(`ACTPDEN_NCK);
      end
      CMD_PRE, CMD_PREA: begin
        cmdOk = exitIdle;
        pdEnVal = 8'(`PRPDEN_NCK);
      end
      CMD_REF: begin
        cmdOk = exitIdle;
        pdEnVal = 8'(`REFPDEN_NCK);
      end
      CMD_RD, CMD_RDA: begin
        cmdOk = exitIdle && dllIdle;
        pdEnVal = 8'({3'h0, readLatency}) + 8'(`RDPDEN_EXTRA);
      end
      CMD_WR: begin
        cmdOk = exitIdle;
        pdEnVal = wrBase + WR_C;
      end
      CMD_WRA: begin
        cmdOk = exitIdle;
        pdEnVal = wrBase + 8'({3'h0, wrCycles}) + 8'h01;
      end
      CMD_MRS: begin
        cmdOk = exitIdle && mrdIdle;
        pdEnVal = MOD_C;
      end
      CMD_PDE: begin
        cmdOk = exitIdle && pdEnIdle && ckeIdle;
      end
      CMD_WLPULSE: begin
        cmdOk = wlMode_q && wlEdgIdle && dqsOe_q;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    // Termination change is synchronous, so it needs the DLL; a fall waits its high time
    odtOk = (req.odt == odt_q) || (exitIdle && dllIdle && (req.odt || termIdle));
  end

  assign take = reqValid && tick && (state_q == ST_RUN) && legal && cmdOk && odtOk;
  // Exit on request or before the longest allowed stay runs out
  assign pdExitNow = tick && (state_q == ST_PD) && ckeIdle
    && ((reqValid && (req.cmd == CMD_PDX)) || (pdCount_q >= PD_LAST));

  // Every timer steps on real memory clock edges only
  nck_timer #(.W(8)) u_pdEn (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(take), .value(pdEnVal), .idle(pdEnIdle)
  );
  nck_timer #(.W(4)) u_exit (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(pdExitNow), .value(XP_C), .idle(exitIdle)
  );
  nck_timer #(.W(4)) u_dll (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(pdExitNow && dllFrozenPd), .value(XPDLL_C), .idle(dllIdle)
  );
  nck_timer #(.W(4)) u_cke (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load((take && (req.cmd == CMD_PDE)) || pdExitNow), .value(CKE_C), .idle(ckeIdle)
  );
  nck_timer #(.W(4)) u_mrd (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(take && (req.cmd == CMD_MRS)), .value(MRD_C), .idle(mrdIdle)
  );
  nck_timer #(.W(4)) u_term (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(take && req.odt && !odt_q),
    .value((isWrite && req.bl8 && !fixedBurstChopMode) ? TERM_HIGH_TIME_LONG_C : TERM_HIGH_TIME_SHORT_C),
    .idle(termIdle)
  );
  nck_timer #(.W(6)) u_wlDrv (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(take && (req.cmd == CMD_MRS) && req.wlMode), .value(WLDQSEN_C), .idle(wlDrvIdle)
  );
  nck_timer #(.W(6)) u_wlEdg (
    .clk(clk), .rst_b(rst_b), .step(tick),
    .load(take && (req.cmd == CMD_MRS) && req.wlMode), .value(WLMRD_C), .idle(wlEdgIdle)
  );

  // Run, power-down, and halt after an illegal request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
    end else if (tick) begin
      unique case (state_q)
        ST_RUN: begin
          if (reqValid && !legal) begin
            state_q <= ST_HALT;
          end else if (take && (req.cmd == CMD_PDE)) begin
            state_q <= ST_PD;
          end
        end
        ST_PD: begin
          if (pdExitNow) begin
            state_q <= ST_RUN;
          end
        end
        ST_HALT: begin
          state_q <= ST_HALT;
        end
        default: begin
          state_q <= ST_HALT;
        end
      endcase
    end
  end

  // Time spent in power-down, in memory cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pdCount_q <= '0;
    end else if (tick) begin
      if (state_q != ST_PD) begin
        pdCount_q <= '0;
      end else if (pdCount_q != PD_LAST) begin
        pdCount_q <= pdCount_q + 1'b1;
      end
    end
  end

  // Clock enable; cleared on entry, raised on exit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cke_q <= 1'b1;
    end else if (tick) begin
      if (take && (req.cmd == CMD_PDE)) begin
        cke_q <= 1'b0;
      end else if (pdExitNow) begin
        cke_q <= 1'b1;
      end
    end
  end

  // Command pins; no-op outside a taken command, so power-down never sees a real one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdPins_q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, ba: 3'h0, addr: 14'h0000};
    end else if (tick) begin
      cmdPins_q.csN <= 1'b0;
      cmdPins_q.ba <= req.bank;
      cmdPins_q.addr <= req.addr;
      {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_NOP;
      if (take) begin
        unique case (req.cmd)
          CMD_ACT: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_ACT;
          CMD_PRE, CMD_PREA: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_PRE;
          CMD_RD, CMD_RDA: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_RD;
          CMD_WR, CMD_WRA: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_WR;
          CMD_REF: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_REF;
          CMD_MRS: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_MRS;
          default: {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN} <= `PIN_NOP;
        endcase
        // Auto-precharge flag follows the command, overriding the user address bit
        if ((req.cmd == CMD_PREA) || (req.cmd == CMD_RDA) || (req.cmd == CMD_WRA)) begin
          cmdPins_q.addr[`AP_BIT] <= 1'b1;
        end else if ((req.cmd == CMD_PRE) || isRead || isWrite) begin
          cmdPins_q.addr[`AP_BIT] <= 1'b0;
        end
      end
    end
  end

  // Termination control follows the request once its checks pass
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      odt_q <= 1'b0;
    end else if (take) begin
      odt_q <= req.odt;
    end
  end

  // Write leveling mode and strobe pair
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wlMode_q <= 1'b0;
      dqs_q <= 1'b0;
      dqsN_q <= 1'b1;
      dqsOe_q <= 1'b0;
    end else if (tick) begin
      if (take && (req.cmd == CMD_MRS)) begin
        wlMode_q <= req.wlMode;
      end
      // Strobe leaves idle only after the drive delay has run
      dqsOe_q <= wlMode_q && wlDrvIdle && !(take && (req.cmd == CMD_MRS) && !req.wlMode);
      dqs_q <= take && (req.cmd == CMD_WLPULSE);
      dqsN_q <= !(take && (req.cmd == CMD_WLPULSE));
    end
  end

  sync_2ff #(.W(1)) u_wlSync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .async(wlDq),
    .synced_q(wlSync)
  );

  // Sample the returned level after the longest output delay plus synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wlWait_q <= 3'h0;
      wlResult_q <= 1'b0;
      wlResultValid_q <= 1'b0;
    end else if (ce) begin
      wlResultValid_q <= 1'b0;
      if (take && (req.cmd == CMD_WLPULSE)) begin
        wlWait_q <= WLO_C;
      end else if (wlWait_q != 3'h0) begin
        wlWait_q <= wlWait_q - 3'h1;
        if (wlWait_q == 3'h1) begin
          wlResult_q <= wlSync;
          wlResultValid_q <= 1'b1;
        end
      end
    end
  end

  // Acknowledge, status flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqAck_q <= 1'b0;
      inPowerDown_q <= 1'b0;
      reinitNeeded_q <= 1'b0;
    end else if (ce) begin
      reqAck_q <= take || (pdExitNow && reqValid && (req.cmd == CMD_PDX));
      inPowerDown_q <= (state_q == ST_PD);
      reinitNeeded_q <= (state_q == ST_HALT) || reinitNeeded_q;
    end
  end

endmodule : dram_pd_timing_host

// *** test/dram_model.sv ***
`timescale 1ns/1ps
`include "dram_pd_timing_regs.svh"

module dram_model
  import dram_pd_timing_pkg::*;
(
  input wire logic ck,
  input wire logic cke,
  input wire pins_t pins,
  input wire logic odt,
  input wire logic dqs,
  output logic dq
);
  logic ckeSeen = 1'b1;
  logic hold = 1'b0;
  logic idleDq = 1'b0;
  logic wlLevel = 1'b0;
  logic termOn = 1'b0;
  int taken = 0;
  // Commands count only on real clock edges with clock enable seen high
  always @(posedge ck) begin
    ckeSeen <= cke;
    if (ckeSeen && cke && !pins.csN && {pins.rasN, pins.casN, pins.weN} != `PIN_NOP) taken++;
  end
  // Frozen power-down: termination follows the pin after a fixed delay
  always @(odt) termOn <= #5 odt;
  // Idle line keeps changing so a stale sample never looks right
  always @(ck) idleDq = ~idleDq;
  // Sampled clock level returned shortly after the strobe rises
  always @(posedge dqs) begin
    hold = 1'b1;
    #1 wlLevel = ck;
    #20 hold = 1'b0;
  end
  // One driver for the data line
  assign dq = hold ? wlLevel : idleDq;
endmodule : dram_model

// *** test/dram_pd_timing_checker.sv ***
`timescale 1ns/1ps
`include "dram_pd_timing_regs.svh"

module dram_pd_timing_checker
  import dram_pd_timing_pkg::*;
#(
  parameter int PD_MAX_NCK = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cke_q,
  input wire pins_t cmdPins_q,
  input wire logic odt_q,
  input wire logic dqsOe_q,
  input wire logic [4:0] readLatency,
  input wire logic [4:0] writeLatency,
  input wire logic [4:0] wrCycles,
  input wire logic fixedBurstChopMode
);
  localparam int MCK = `CLK_PERIOD_PS * `CK_DIV;
  localparam int WRR = (`WR_PS + MCK - 1) / MCK;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [2:0] code;
  logic isCmd;
  logic isMrs;
  logic isRd;
  logic isWr;
  logic [8:0] mrsAge_q, rdAge_q, wrAge_q, wraAge_q;
  logic [15:0] pdLen_q;
  int bc;
  // Pin decode and burst part of the write-to-entry wait
  assign code = {cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN};
  assign isCmd = !cmdPins_q.csN && code != `PIN_NOP;
  assign isMrs = !cmdPins_q.csN && code == `PIN_MRS;
  assign isRd = !cmdPins_q.csN && code == `PIN_RD;
  assign isWr = !cmdPins_q.csN && code == `PIN_WR;
  assign bc = fixedBurstChopMode ? `WRPDEN_BC4_EXTRA : `WRPDEN_BL8_EXTRA;
  // Clocks since each mode set, read, write and auto-precharge write launched; saturates so old history never fires
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mrsAge_q <= 9'h1FF;
      rdAge_q <= 9'h1FF;
      wrAge_q <= 9'h1FF;
      wraAge_q <= 9'h1FF;
    end else begin
      mrsAge_q <= $rose(isMrs) ? 9'h000 : mrsAge_q + 9'(mrsAge_q != 9'h1FF);
      rdAge_q <= $rose(isRd) ? 9'h000 : rdAge_q + 9'(rdAge_q != 9'h1FF);
      wrAge_q <= $rose(isWr && !cmdPins_q.addr[`AP_BIT]) ? 9'h000 : wrAge_q + 9'(wrAge_q != 9'h1FF);
      wraAge_q <= $rose(isWr && cmdPins_q.addr[`AP_BIT]) ? 9'h000 : wraAge_q + 9'(wraAge_q != 9'h1FF);
    end
  end
  // Length of the current power-down in clocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pdLen_q <= 16'h0000;
    else pdLen_q <= cke_q ? 16'h0000 : pdLen_q + 16'h0001;
  end
  property p_cke_hold;
    $changed(cke_q) |=> $stable(cke_q) [*5];
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("clock enable pulse too short");
  property p_exit_quiet;
    $rose(cke_q) |-> !isCmd [*6];
  endproperty
  a_exit_quiet: assert property (p_exit_quiet) else $error("command too soon after exit");
  property p_mrs_space;
    $rose(isMrs) |=> ##1 !isMrs [*6];
  endproperty
  a_mrs_space: assert property (p_mrs_space) else $error("mode sets too close");
  property p_term_high;
    $rose(odt_q) |-> odt_q [*8];
  endproperty
  a_term_high: assert property (p_term_high) else $error("termination high too short");
  property p_mrs_pde;
    $fell(cke_q) |-> int'(mrsAge_q) >= 2 * `MOD_NCK - 1;
  endproperty
  a_mrs_pde: assert property (p_mrs_pde) else $error("entry too soon after mode set");
  property p_rd_pde;
    $fell(cke_q) |-> int'(rdAge_q) >= 2 * (int'(readLatency) + `RDPDEN_EXTRA) - 1;
  endproperty
  a_rd_pde: assert property (p_rd_pde) else $error("entry too soon after read");
  property p_wr_pde;
    $fell(cke_q) |-> int'(wrAge_q) >= 2 * (int'(writeLatency) + bc + WRR) - 1;
  endproperty
  a_wr_pde: assert property (p_wr_pde) else $error("entry too soon after write");
  property p_wra_pde;
    $fell(cke_q) |-> int'(wraAge_q) >= 2 * (int'(writeLatency) + bc + int'(wrCycles) + 1) - 1;
  endproperty
  a_wra_pde: assert property (p_wra_pde) else $error("entry too soon after write ap");
  property p_strobe_en;
    $rose(dqsOe_q) |-> int'(mrsAge_q) >= 2 * `WLDQSEN_NCK - 1;
  endproperty
  a_strobe_en: assert property (p_strobe_en) else $error("strobe driven too soon");
  property p_pd_max;
    int'(pdLen_q) <= 2 * PD_MAX_NCK + 6;
  endproperty
  a_pd_max: assert property (p_pd_max) else $error("power-down too long");
endmodule : dram_pd_timing_checker

bind dram_pd_timing_host dram_pd_timing_checker #(.PD_MAX_NCK(PD_MAX_NCK)) uChk (.clk(clk), .rst_b(rst_b),
  .cke_q(cke_q), .cmdPins_q(cmdPins_q), .odt_q(odt_q), .dqsOe_q(dqsOe_q), .readLatency(readLatency),
  .writeLatency(writeLatency), .wrCycles(wrCycles), .fixedBurstChopMode(fixedBurstChopMode));

// *** test/testbench.sv ***
`timescale 1ns/1ps
`include "dram_pd_timing_regs.svh"

module testbench
  import dram_pd_timing_pkg::*;
;
  localparam int PDMAX = 20;
  localparam int MCK = `CLK_PERIOD_PS * `CK_DIV;
  typedef struct packed {logic [10:0] exp; logic [10:0] mask; logic [7:0] gap;} note_t;
  logic clk, rst_b, ce, reqValid, reqAck_q, fixedBurstChopMode, dllFrozenPd;
  logic [4:0] readLatency, writeLatency, wrCycles;
  logic ddrCk_q, ddrCkN_q, cke_q, odt_q, dqs_q, dqsN_q, dqsOe_q, wlDq, wlResult_q, wlResultValid_q;
  logic inPowerDown_q, reinitNeeded_q;
  req_t req;
  pins_t cmdPins_q;
  note_t noteQ[$];
  logic wlQ[$];
  note_t n;
  int err_count, checks, tk, lastTk, i, k, seed, cmdN;
  cmd_t seq[10] = '{CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_WR, CMD_WRA};

  dram_pd_timing_host #(.PD_MAX_NCK(PDMAX)) uut (.clk(clk), .rst_b(rst_b), .ce(ce), .reqValid(reqValid),
    .req(req), .reqAck_q(reqAck_q), .readLatency(readLatency), .writeLatency(writeLatency),
    .wrCycles(wrCycles), .fixedBurstChopMode(fixedBurstChopMode), .dllFrozenPd(dllFrozenPd),
    .ddrCk_q(ddrCk_q), .ddrCkN_q(ddrCkN_q), .cke_q(cke_q), .cmdPins_q(cmdPins_q), .odt_q(odt_q),
    .dqs_q(dqs_q), .dqsN_q(dqsN_q), .dqsOe_q(dqsOe_q), .wlDq(wlDq), .wlResult_q(wlResult_q),
    .wlResultValid_q(wlResultValid_q), .inPowerDown_q(inPowerDown_q), .reinitNeeded_q(reinitNeeded_q));
  dram_model mem (.ck(ddrCk_q), .cke(cke_q), .pins(cmdPins_q), .odt(odt_q), .dqs(dqs_q), .dq(wlDq));

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic final_report();
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Minimum wait before power-down entry after each command kind except mode-register set, which falls to the default of one
  function automatic int entryGap(input cmd_t c);
    int b;
    b = fixedBurstChopMode ? `WRPDEN_BC4_EXTRA : `WRPDEN_BL8_EXTRA;
    case (c)
      CMD_RD, CMD_RDA: return readLatency + `RDPDEN_EXTRA;
      CMD_WR: return writeLatency + b + (`WR_PS + MCK - 1) / MCK;
      CMD_WRA: return writeLatency + b + wrCycles + 1;
      default: return 1;
    endcase
  endfunction : entryGap

  // One request: note the expected pins, hold until acknowledged, then release
  task automatic issue(input cmd_t c, input logic o, input logic b8, input logic wl, input int gap);
    note_t nt;
    logic [2:0] p;
    int j;
    case (c)
      CMD_ACT: p = `PIN_ACT;
      CMD_PRE, CMD_PREA: p = `PIN_PRE;
      CMD_RD, CMD_RDA: p = `PIN_RD;
      CMD_WR, CMD_WRA: p = `PIN_WR;
      CMD_REF: p = `PIN_REF;
      CMD_MRS: p = `PIN_MRS;
      default: p = `PIN_NOP;
    endcase
    // Real commands the memory should register while clock enable is high
    if (p != `PIN_NOP) cmdN++;
    nt.exp = {1'b0, p, c inside {CMD_RDA, CMD_WRA, CMD_PREA}, c != CMD_PDE, o, c == CMD_PDX, c == CMD_WLPULSE,
      c != CMD_WLPULSE, 1'b1};
    nt.mask = {{4{!(c inside {CMD_PDE, CMD_PDX, CMD_WLPULSE})}}, c inside {[CMD_PRE:CMD_WRA]}, 6'h3F};
    nt.gap = 8'(gap);
    noteQ.push_back(nt);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{cmd: c, bl8: b8, odt: o, wlMode: wl, bank: 3'($random(seed)), addr: 14'($random(seed))};
    for (j = 0; j < 600; j++) begin
      @(posedge clk);
      if (reqAck_q === 1'b1) break;
    end
    chk(16'(j < 600), 16'h1);
    reqValid <= 1'b0;
  endtask : issue

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Checker side: oldest note against each acknowledged command
  always @(negedge clk) begin
    if (!ddrCk_q) tk++;
    if (reqAck_q === 1'b1) begin
      if (noteQ.size() == 0) chk(16'h1, 16'h0);
      else begin
        n = noteQ.pop_front();
        chk(16'({cmdPins_q.csN, cmdPins_q.rasN, cmdPins_q.casN, cmdPins_q.weN, cmdPins_q.addr[`AP_BIT],
          cke_q, odt_q, inPowerDown_q, dqs_q, dqsN_q, ddrCkN_q} & n.mask), 16'(n.exp & n.mask));
        chk(16'(tk - lastTk >= n.gap), 16'h1);
        lastTk = tk;
      end
    end
    if (wlResultValid_q === 1'b1 && wlQ.size() > 0) chk(16'(wlResult_q), 16'(wlQ.pop_front()));
  end

  // Watchdog well beyond the expected run
  initial begin
    #100000;
    err_count++;
    final_report();
  end

  initial begin
    seed = 32'h5E82D7DB;
    rst_b = 1'b0;
    ce = 1'b1;
    reqValid = 1'b0;
    req = '0;
    fixedBurstChopMode = 1'b0;
    dllFrozenPd = 1'b0;
    readLatency = 5'(5 + ($random(seed) & 7));
    writeLatency = 5'(5 + ($random(seed) & 7));
    wrCycles = 5'(5 + ($random(seed) & 7));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    issue(CMD_MRS, 1'b0, 1'b0, 1'b0, 0);
    issue(CMD_MRS, 1'b0, 1'b0, 1'b0, `MRD_NCK);
    issue(CMD_PDE, 1'b0, 1'b0, 1'b0, `MOD_NCK);
    for (i = 0; i < 10; i++) begin
      if (i == 8) fixedBurstChopMode <= 1'b1;
      issue(CMD_PDX, 1'b0, 1'b0, 1'b0, `CKE_NCK);
      issue(seq[i], 1'b0, 1'b1, 1'b0, `XP_NCK);
      issue(CMD_PDE, 1'b0, 1'b0, 1'b0, entryGap(seq[i]));
    end
    fixedBurstChopMode <= 1'b0;
    dllFrozenPd <= 1'b1;
    issue(CMD_PDX, 1'b0, 1'b0, 1'b0, `CKE_NCK);
    issue(CMD_RD, 1'b0, 1'b0, 1'b0, `XPDLL_NCK);
    issue(CMD_PDE, 1'b0, 1'b0, 1'b0, entryGap(CMD_RD));
    dllFrozenPd <= 1'b0;
    issue(CMD_PDX, 1'b0, 1'b0, 1'b0, `CKE_NCK);
    issue(CMD_NOP, 1'b1, 1'b0, 1'b0, `XP_NCK);
    issue(CMD_NOP, 1'b0, 1'b0, 1'b0, `TERM_HIGH_TIME_SHORT_NCK);
    issue(CMD_WR, 1'b1, 1'b1, 1'b0, 0);
    issue(CMD_NOP, 1'b0, 1'b0, 1'b0, `TERM_HIGH_TIME_LONG_NCK);
    issue(CMD_MRS, 1'b0, 1'b0, 1'b1, 0);
    wlQ.push_back(1'b0);
    issue(CMD_WLPULSE, 1'b0, 1'b0, 1'b0, `WLMRD_NCK);
    issue(CMD_MRS, 1'b0, 1'b0, 1'b0, 0);
    issue(CMD_MRS, 1'b0, 1'b0, 1'b0, `MRD_NCK);
    issue(CMD_PDE, 1'b0, 1'b0, 1'b0, `MOD_NCK);
    for (k = 0; k < 200 && cke_q !== 1'b1; k++) @(posedge clk);
    chk(16'(k > 2 * PDMAX + 8 || k < 2 * `CKE_NCK), 16'h0);
    @(posedge clk);
    reqValid <= 1'b1;
    req.cmd <= cmd_t'(4'hD);
    for (k = 0; k < 50 && reinitNeeded_q !== 1'b1; k++) @(posedge clk);
    chk(16'(reinitNeeded_q), 16'h1);
    repeat (20) @(posedge clk);
    reqValid <= 1'b0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk(16'({reinitNeeded_q, cke_q, odt_q, dqsOe_q}), 16'h4);
    rst_b <= 1'b1;
    issue(CMD_REF, 1'b0, 1'b0, 1'b0, 0);
    repeat (8) @(posedge clk);
    chk(16'(wlQ.size()), 16'h0);
    chk(16'(mem.taken), 16'(cmdN));
    final_report();
  end
endmodule : testbench
